// ===== verilog/sges_map.svh
// register offsets, field positions and reset values of the event status logic
// Behaviour
// - sleep with all wake sources disabled resets
// - sleep command with pending event enters reset
// - sleep inhibit turns sleep into serial failure
// - flags clear on write one only
// - summary bit 3 follows wake-pin flags
// - summary bit 2 follows transceiver flags
// - summary bit 1 follows supply flags
// - summary bit 0 follows system flags
// - battery startup flag set leaving off
// - overheat flag set outside sleep only
// - serial failures set flag outside sleep
// - watchdog overflow, or early trigger in window mode, sets fault
// - timeout overflow resets only if fault pending
// - startup, watchdog, frame error always captured
// - offline capture with supply on pulls receive low
// - capture in sleep powers host, goes standby
`ifndef SGES_MAP_SVH
`define SGES_MAP_SVH
`define SGES_ADDR_SUMMARY  8'h60
`define SGES_ADDR_SYSTEM   8'h61
`define SGES_ADDR_SUPPLY   8'h62
`define SGES_ADDR_TRX      8'h63
`define SGES_ADDR_WAKE     8'h64
`define SGES_BIT_START     4
`define SGES_BIT_HEAT      2
`define SGES_BIT_SERIAL    1
`define SGES_BIT_WDOG      0
`define SGES_SYS_MASK      8'h17
`define SGES_SUP_MASK      8'h07
`define SGES_TRX_MASK      8'h33
`define SGES_WAKE_MASK     8'h03
`define SGES_TRX_FDE_BIT   5
`define SGES_MODE_SLEEP    3'h1
`define SGES_MODE_STANDBY  3'h4
`define SGES_MODE_NORMAL   3'h7
`define SGES_FLAGS_RESET   8'h00
`endif

// ===== verilog/sges_pkg.sv
// types of the event status logic
`default_nettype none
package sges_pkg;
  typedef enum logic [2:0] {
    SGES_OFF,
    SGES_NORMAL,
    SGES_STANDBY,
    SGES_RESET,
    SGES_SLEEP
  } sges_state_t;
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sges_reg_req_t;
  typedef struct packed {
    logic wdog_overflow;
    logic wdog_early;
    logic wdog_window;
    logic wdog_timeout;
    logic serial_error;
    logic overheat;
  } sges_sys_ev_t;
endpackage
`default_nettype wire

// ===== verilog/sges_flag_reg.sv
// generic write-one-to-clear flag register with set priority
`timescale 1ns/1ps
`default_nettype none
`include "sges_map.svh"
module sges_flag_reg #(
  parameter logic [7:0] MASK = 8'hFF
) (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic [7:0] set_bits,
  input  wire logic       clr_en,
  input  wire logic [7:0] clr_bits,
  output var  logic [7:0] flags_q,
  output var  logic       any_pending
);
  logic [7:0] flags_d;
  // a set in the clearing cycle wins, so no event is lost
  always_comb
  begin
    flags_d = flags_q & ~(clr_en ? clr_bits : 8'h00);
    flags_d = (flags_d | set_bits) & MASK;
  end
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      flags_q <= `SGES_FLAGS_RESET;
    else
      flags_q <= flags_d;
  end
  assign any_pending = |flags_q;
  a_clear_zero_keeps: assert property (@(posedge clock)
    disable iff (!rstn)
    (clr_en && (clr_bits & flags_q) == 8'h00) |=>
      ((flags_q & $past(flags_q)) == $past(flags_q)))
    else $error("write of zero changed a flag");
endmodule
`default_nettype wire

// ===== verilog/sges_core.sv
// sleep guard and event status top level
`timescale 1ns/1ps
`default_nettype none
`include "sges_map.svh"
module sges_core (
  input  wire logic                   clock,
  input  wire logic                   rstn,
  input  wire sges_pkg::sges_reg_req_t reg_req,
  output logic [7:0]                  reg_rdata_q,
  input  wire logic [2:0]             operating_state_code,
  input  wire logic                   mode_cmd_valid,
  input  wire logic                   sleep_inhibit_bit,
  input  wire logic                   wake_bus_en,
  input  wire logic                   wake_rise_en,
  input  wire logic                   wake_fall_en,
  input  wire logic                   heat_capture_en,
  input  wire logic                   serial_capture_en,
  input  wire sges_pkg::sges_sys_ev_t sys_ev,
  input  wire logic                   left_off,
  input  wire logic [7:0]             supply_ev,
  input  wire logic [7:0]             trx_ev,
  input  wire logic [7:0]             wake_ev,
  input  wire logic                   trx_offline,
  output logic                        rxd_low_q,
  output logic                        sys_reset_q,
  output logic                        host_supply_q,
  output sges_pkg::sges_state_t       state_q
);
  logic       in_sleep;
  logic [7:0] sys_set;
  logic [7:0] sys_q;
  logic [7:0] sup_q;
  logic [7:0] trx_q;
  logic [7:0] wak_q;
  logic       sys_p;
  logic       sup_p;
  logic       trx_p;
  logic       wak_p;
  logic [7:0] summary;
  logic       any_ev;
  logic       sleep_cmd;
  logic       wake_none;
  logic       wdog_fail;
  logic       wdog_reset;
  logic [7:0] cap_all;
  logic       captured;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = reg_req.wr && (a == b);
  endfunction

  assign in_sleep  = (state_q == sges_pkg::SGES_SLEEP);
  assign sleep_cmd = mode_cmd_valid &&
                     operating_state_code == `SGES_MODE_SLEEP;
  assign wake_none = !(wake_bus_en || wake_rise_en || wake_fall_en);
  assign any_ev    = sys_p | sup_p | trx_p | wak_p;
  assign wdog_fail = sys_ev.wdog_overflow ||
                     (sys_ev.wdog_early && sys_ev.wdog_window);
  // window failure resets at once; timeout only on a repeated fault
  assign wdog_reset = (wdog_fail && sys_ev.wdog_window) ||
                      (sys_ev.wdog_overflow && sys_ev.wdog_timeout &&
                       sys_q[`SGES_BIT_WDOG]);

  always_comb
  begin
    sys_set = 8'h00;
    sys_set[`SGES_BIT_START] = left_off;
    sys_set[`SGES_BIT_WDOG]  = wdog_fail;
    sys_set[`SGES_BIT_HEAT]  = heat_capture_en && sys_ev.overheat &&
                               !in_sleep;
    sys_set[`SGES_BIT_SERIAL] = serial_capture_en && !in_sleep &&
                                (sys_ev.serial_error ||
                                 (sleep_cmd && sleep_inhibit_bit));
  end

  sges_flag_reg #(.MASK(`SGES_SYS_MASK)) u_sys (
    .clock(clock), .rstn(rstn), .set_bits(sys_set),
    .clr_en(hit(reg_req.addr, `SGES_ADDR_SYSTEM)),
    .clr_bits(reg_req.wdata), .flags_q(sys_q), .any_pending(sys_p));
  sges_flag_reg #(.MASK(`SGES_SUP_MASK)) u_sup (
    .clock(clock), .rstn(rstn), .set_bits(supply_ev),
    .clr_en(hit(reg_req.addr, `SGES_ADDR_SUPPLY)),
    .clr_bits(reg_req.wdata), .flags_q(sup_q), .any_pending(sup_p));
  sges_flag_reg #(.MASK(`SGES_TRX_MASK)) u_trx (
    .clock(clock), .rstn(rstn), .set_bits(trx_ev),
    .clr_en(hit(reg_req.addr, `SGES_ADDR_TRX)),
    .clr_bits(reg_req.wdata), .flags_q(trx_q), .any_pending(trx_p));
  sges_flag_reg #(.MASK(`SGES_WAKE_MASK)) u_wak (
    .clock(clock), .rstn(rstn), .set_bits(wake_ev),
    .clr_en(hit(reg_req.addr, `SGES_ADDR_WAKE)),
    .clr_bits(reg_req.wdata), .flags_q(wak_q), .any_pending(wak_p));

  // supply, transceiver and wake inputs arrive already gated by capture enables
  assign cap_all  = sys_set | supply_ev | trx_ev | wake_ev;
  assign captured = |cap_all;
  assign summary  = {4'h0, wak_p, trx_p, sup_p, sys_p};

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      reg_rdata_q <= 8'h00;
    else
    begin
      case (reg_req.addr)
        `SGES_ADDR_SUMMARY: reg_rdata_q <= summary;
        `SGES_ADDR_SYSTEM:  reg_rdata_q <= sys_q;
        `SGES_ADDR_SUPPLY:  reg_rdata_q <= sup_q;
        `SGES_ADDR_TRX:     reg_rdata_q <= trx_q;
        `SGES_ADDR_WAKE:    reg_rdata_q <= wak_q;
        default:            reg_rdata_q <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      rxd_low_q <= 1'b0;
    else
      rxd_low_q <= trx_offline && host_supply_q && any_ev;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      sys_reset_q <= 1'b0;
    else
      sys_reset_q <= wdog_reset ||
                     (sleep_cmd && !sleep_inhibit_bit &&
                      (wake_none || any_ev));
  end

  // state stays off until the startup event, then walks through reset
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      state_q <= sges_pkg::SGES_OFF;
    else
    begin
      case (state_q)
        sges_pkg::SGES_OFF:
          if (left_off)
            state_q <= sges_pkg::SGES_RESET;
        sges_pkg::SGES_RESET:
          state_q <= sges_pkg::SGES_STANDBY;
        sges_pkg::SGES_SLEEP:
          if (captured)
            state_q <= sges_pkg::SGES_RESET;
        default:
          if (wdog_reset)
            state_q <= sges_pkg::SGES_RESET;
          else if (sleep_cmd && !sleep_inhibit_bit)
          begin
            if (wake_none || any_ev)
              state_q <= sges_pkg::SGES_RESET;
            else
              state_q <= sges_pkg::SGES_SLEEP;
          end
          else if (mode_cmd_valid &&
                   operating_state_code == `SGES_MODE_NORMAL)
            state_q <= sges_pkg::SGES_NORMAL;
          else if (mode_cmd_valid &&
                   operating_state_code == `SGES_MODE_STANDBY)
            state_q <= sges_pkg::SGES_STANDBY;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      host_supply_q <= 1'b0;
    else if (state_q == sges_pkg::SGES_SLEEP && captured)
      host_supply_q <= 1'b1;
    else if (state_q == sges_pkg::SGES_SLEEP ||
             state_q == sges_pkg::SGES_OFF)
      host_supply_q <= 1'b0;
    else
      host_supply_q <= 1'b1;
  end

  a_sleep_no_wake: assert property (@(posedge clock)
    disable iff (!rstn)
    (state_q != sges_pkg::SGES_SLEEP && sleep_cmd && !sleep_inhibit_bit &&
     wake_none && !wdog_reset && state_q != sges_pkg::SGES_OFF &&
     state_q != sges_pkg::SGES_RESET) |=>
      (state_q == sges_pkg::SGES_RESET && sys_reset_q))
    else $error("sleep without wake source did not reset");
  a_sleep_pending: assert property (@(posedge clock)
    disable iff (!rstn)
    (sleep_cmd && !sleep_inhibit_bit && any_ev) |=>
      (state_q != sges_pkg::SGES_SLEEP && sys_reset_q))
    else $error("sleep entered with pending event");
  a_inhibit_sleep: assert property (@(posedge clock)
    disable iff (!rstn)
    (sleep_cmd && sleep_inhibit_bit && serial_capture_en && !in_sleep) |=>
      (sys_q[`SGES_BIT_SERIAL] && state_q != sges_pkg::SGES_SLEEP))
    else $error("inhibited sleep mishandled");
  a_summary_or: assert property (@(posedge clock)
    disable iff (!rstn)
    (reg_req.addr == `SGES_ADDR_SUMMARY) |=>
      (reg_rdata_q == {4'h0, $past(wak_q) != 8'h00,
                       $past(trx_q) != 8'h00, $past(sup_q) != 8'h00,
                       $past(sys_q) != 8'h00}))
    else $error("summary does not follow flags");
  a_heat_sleep: assert property (@(posedge clock)
    disable iff (!rstn)
    (in_sleep && sys_q[`SGES_BIT_HEAT] == 1'b0) |=>
      !sys_q[`SGES_BIT_HEAT])
    else $error("overheat captured in sleep");
  a_wdog_set: assert property (@(posedge clock)
    disable iff (!rstn)
    wdog_fail |=> sys_q[`SGES_BIT_WDOG])
    else $error("watchdog fault not captured");
  a_window_reset: assert property (@(posedge clock)
    disable iff (!rstn)
    (sys_ev.wdog_window && sys_ev.wdog_overflow) |=> sys_reset_q)
    else $error("window failure did not reset");
  a_timeout_first: assert property (@(posedge clock)
    disable iff (!rstn)
    (sys_ev.wdog_timeout && !sys_ev.wdog_window && !sys_q[`SGES_BIT_WDOG]
     && !sleep_cmd) |=> !sys_reset_q)
    else $error("first timeout overflow reset");
  a_sleep_wake: assert property (@(posedge clock)
    disable iff (!rstn)
    (in_sleep && captured) |=> (state_q == sges_pkg::SGES_RESET &&
      host_supply_q) ##1 (state_q == sges_pkg::SGES_STANDBY))
    else $error("sleep capture did not wake");
  a_rxd_event: assert property (@(posedge clock)
    disable iff (!rstn)
    (trx_offline && host_supply_q && any_ev) |=> rxd_low_q)
    else $error("receive pin not pulled low");
endmodule
`default_nettype wire

// ===== testbench/sges_host_model.sv
// host side register access model for the event status logic
`timescale 1ns/1ps
`default_nettype none
module sges_host_model (
  input  wire logic                     clock,
  output var  sges_pkg::sges_reg_req_t  reg_req,
  input  wire logic [7:0]               reg_rdata_q
);
  initial reg_req = '0;
  // the host clears flags by writing ones; the bench writes all ones, set or not
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clock);
    reg_req = '{1'b1, a, v};
    @(negedge clock);
    reg_req.wr = 1'b0;
  endtask
  // data is registered, so it is taken one full cycle after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge clock);
    reg_req = '{1'b0, a, 8'h00};
    @(negedge clock);
    v = reg_rdata_q;
  endtask
endmodule
`default_nettype wire

// ===== testbench/testbench.sv
// self-checking bench for the event status logic
`timescale 1ns/1ps
`default_nettype none
`include "sges_map.svh"
module testbench;
  logic       clock = 1'b0;
  logic       rstn = 1'b0;
  logic       cv = 1'b0;
  logic [2:0] code = 3'h0;
  logic       inh = 1'b0;
  logic [2:0] wk_en = 3'h0;
  logic       heat_en = 1'b0;
  logic       ser_en = 1'b0;
  logic       lo = 1'b0;
  logic       offl = 1'b0;
  logic [7:0] su = 8'h00;
  logic [7:0] tr = 8'h00;
  logic [7:0] wk = 8'h00;
  logic [7:0] rdata;
  logic [7:0] d;
  logic [23:0] x;
  logic       rxd_low_q;
  logic       sys_reset_q;
  logic       host_supply_q;
  logic [5:0] wd [2] = '{6'h28, 6'h18};
  sges_pkg::sges_reg_req_t reg_req;
  sges_pkg::sges_sys_ev_t  sys_ev = '0;
  sges_pkg::sges_state_t   state_q;
  int         m [5] = '{0, 0, 0, 0, 0};
  int         n_fail = 0;
  int         samples_checked = 0;
  int         n_rst = 0;
  int         n0;
  int         i;
  always #4 clock = ~clock;
  always @(posedge clock) if (sys_reset_q === 1'b1) n_rst++;
  sges_host_model host_i (.clock(clock), .reg_req(reg_req),
    .reg_rdata_q(rdata));
  sges_core sges_core_i (.clock(clock), .rstn(rstn), .reg_req(reg_req),
    .reg_rdata_q(rdata), .operating_state_code(code), .mode_cmd_valid(cv),
    .sleep_inhibit_bit(inh), .wake_bus_en(wk_en[0]),
    .wake_rise_en(wk_en[1]), .wake_fall_en(wk_en[2]),
    .heat_capture_en(heat_en), .serial_capture_en(ser_en),
    .sys_ev(sys_ev), .left_off(lo), .supply_ev(su), .trx_ev(tr),
    .wake_ev(wk), .trx_offline(offl), .rxd_low_q(rxd_low_q),
    .sys_reset_q(sys_reset_q), .host_supply_q(host_supply_q),
    .state_q(state_q));
  task automatic test_done;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // index 0 is the summary, worked out from the modelled flags
  task automatic rc(input int k);
    host_i.rd(8'h60 + 8'(k), d);
    chk(d, k == 0 ? {4'h0, m[4] != 0, m[3] != 0, m[2] != 0, m[1] != 0}
      : 8'(m[k]));
  endtask
  task automatic clr(input int k);
    host_i.wr(8'h60 + 8'(k), 8'hFF);
    m[k] = 0;
  endtask
  // s: overflow, early, window, timeout, serial, overheat
  task automatic ev(input logic [5:0] s, input logic l, input logic [23:0] x);
    @(negedge clock);
    sys_ev = s;
    lo = l;
    {wk, tr, su} = x;
    @(negedge clock);
    sys_ev = '0;
    lo = 1'b0;
    {wk, tr, su} = 24'h0;
  endtask
  task automatic cmd(input logic [2:0] c);
    @(negedge clock);
    code = c;
    cv = 1'b1;
    @(negedge clock);
    cv = 1'b0;
  endtask
  // reset and off both hold off mode commands, so wait them out
  task automatic settle;
    int k;
    k = 0;
    while (state_q inside {sges_pkg::SGES_RESET, sges_pkg::SGES_OFF} && k < 20)
    begin
      @(negedge clock);
      k++;
    end
    if (k == 20)
    begin
      n_fail++;
      test_done;
    end
  endtask
  initial
  begin
    void'($urandom(32'hA453));
    repeat (4) @(posedge clock);
    @(negedge clock) rstn = 1'b1;
    chk(8'(state_q), 8'(sges_pkg::SGES_OFF));
    ev(6'h00, 1'b1, 24'h0);
    m[1] = 32'h10;
    rc(1);
    rc(0);
    host_i.wr(8'h61, 8'h00);
    host_i.wr(8'h70, 8'hFF);
    rc(1);
    clr(1);
    rc(1);
    repeat (4)
    begin
      repeat (2)
      begin
        x = {8'($urandom), 8'($urandom), 8'($urandom)};
        ev(6'h00, 1'b0, x);
        m[2] |= int'(x[7:0] & `SGES_SUP_MASK);
        m[3] |= int'(x[15:8] & `SGES_TRX_MASK);
        m[4] |= int'(x[23:16] & `SGES_WAKE_MASK);
      end
      host_i.wr(`SGES_ADDR_SUMMARY, 8'hFF);
      rc(0);
      chk(8'(rxd_low_q), 8'h00);
      for (i = 2; i < 5; i++) rc(i);
      for (i = 2; i < 5; i++) clr(i);
      rc(0);
    end
    for (i = 0; i < 3; i++)
    begin
      heat_en = 1'(i == 0);
      ser_en = 1'(i == 0);
      ev(6'h03, 1'b0, 24'h0);
      m[1] = i == 0 ? 32'h6 : 32'h0;
      rc(1);
      clr(1);
    end
    for (i = 0; i < 2; i++)
    begin
      n0 = n_rst;
      ev(wd[i], 1'b0, 24'h0);
      m[1] = 1;
      rc(1);
      chk(8'(n_rst - n0), 8'h01);
      settle;
      clr(1);
    end
    n0 = n_rst;
    ev(6'h24, 1'b0, 24'h0);
    m[1] = 1;
    rc(1);
    chk(8'(n_rst - n0), 8'h00);
    ev(6'h24, 1'b0, 24'h0);
    rc(1);
    chk(8'(n_rst - n0), 8'h01);
    settle;
    clr(1);
    n0 = n_rst;
    cmd(`SGES_MODE_SLEEP);
    chk(8'(state_q), 8'(sges_pkg::SGES_RESET));
    settle;
    chk(8'(n_rst - n0), 8'h01);
    wk_en = 3'h1 << $urandom_range(2);
    heat_en = 1'b1;
    ev(6'h01, 1'b0, 24'h0);
    m[1] = 32'h4;
    rc(1);
    n0 = n_rst;
    cmd(`SGES_MODE_SLEEP);
    chk(8'(state_q), 8'(sges_pkg::SGES_RESET));
    settle;
    chk(8'(n_rst - n0), 8'h01);
    clr(1);
    inh = 1'b1;
    ser_en = 1'b1;
    cmd(`SGES_MODE_SLEEP);
    m[1] = 2;
    rc(1);
    chk(8'(state_q == sges_pkg::SGES_SLEEP), 8'h00);
    clr(1);
    inh = 1'b0;
    cmd(`SGES_MODE_SLEEP);
    chk(8'(state_q), 8'(sges_pkg::SGES_SLEEP));
    repeat (2) @(negedge clock);
    chk(8'(host_supply_q), 8'h00);
    offl = 1'b1;
    ev(6'h00, 1'b0, 24'h010000);
    m[4] = 1;
    settle;
    chk(8'(host_supply_q), 8'h01);
    chk(8'(state_q), 8'(sges_pkg::SGES_STANDBY));
    rc(0);
    clr(4);
    ev(6'h00, 1'b0, 24'h020000);
    @(negedge clock);
    chk(8'(rxd_low_q), 8'h01);
    test_done;
  end
endmodule
`default_nettype wire
